// *** harvard_core.sv ***
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "harvard_core_defines.svh"
module harvard_core #(
    parameter int PC_W       = 11,
    parameter int NUM_BANKS  = 4,
    parameter int WDT_CYCLES = 4096
) (
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        arst_n,
    // axi4-lite slave
    input  wire logic [7:0]                  awaddr,
    input  wire logic [2:0]                  awprot,
    input  wire logic                        awvalid,
    output logic                             awready,
    input  wire logic [31:0]                 wdata,
    input  wire logic [3:0]                  wstrb,
    input  wire logic                        wvalid,
    output logic                             wready,
    output logic [1:0]                       bresp,
    output logic                             bvalid,
    input  wire logic                        bready,
    input  wire logic [7:0]                  araddr,
    input  wire logic [2:0]                  arprot,
    input  wire logic                        arvalid,
    output logic                             arready,
    output logic [31:0]                      rdata,
    output logic [1:0]                       rresp,
    output logic                             rvalid,
    input  wire logic                        rready,
    // program memory and fuses
    output logic [PC_W-1:0]                  progAddr,
    input  wire logic [11:0]                 progData,
    input  wire logic [11:0]                 fuseWord,
    input  wire logic [15:0]                 idBits,
    // i/o ports and oscillator selection
    input  wire logic [23:0]                 portPins,
    output logic [23:0]                      portLatch,
    output harvard_core_pkg::osc_mode_t      oscMode
);
    localparam int RAM_N = 8 + NUM_BANKS * 16;
    localparam int RI_W  = 7;
    localparam int WDT_W = $clog2(WDT_CYCLES);

    if (PC_W < 9 || PC_W > 11 || NUM_BANKS < 1 || NUM_BANKS > 4 ||
        WDT_CYCLES < 2) begin : gBadParam
        $error("harvard_core: unsupported parameter value");
    end

    logic [23:0]               pinMeta_r, pinSync_r;
    logic                      cfgLoaded_r;
    logic [11:0]               fuse_r, fuseNxt;
    logic [15:0]               id_r, idNxt;
    harvard_core_pkg::osc_mode_t oscMode_r, oscModeNxt;
    logic [PC_W-1:0]           pc_r, pcNxt, stk1_r, stk1Nxt, stk2_r, stk2Nxt;
    logic [11:0]               ir_r, irNxt;
    logic [7:0]                w_r, wNxt, status_r, statusNxt;
    logic [7:0]                fsr_r, fsrNxt, evt_r, evtNxt;
    logic [23:0]               port_r, portNxt;
    logic [7:0]                ram_r [RAM_N];
    logic [7:0]                ramNxt [RAM_N];
    logic [WDT_W-1:0]          wdtCnt_r, wdtNxt;
    logic                      wdtFire, active, ind, ramHit, flush;
    logic                      wrF, toW, dfs, zUpd, cUpd;
    logic [4:0]                eAddr;
    logic [1:0]                eBank, portSel, page;
    logic [RI_W-1:0]           ramIdx;
    logic [7:0]                fRd, res, lit, bitMask;
    logic [8:0]                sum;
    logic [10:0]               tgt;
    logic                      awHeld_r, awHeldNxt, wHeld_r, wHeldNxt;
    logic [7:0]                awAddr_r, awAddrNxt;
    logic [31:0]               wData_r, wDataNxt, rdataNxt;
    logic [3:0]                wStrb_r, wStrbNxt;
    logic                      bvalidNxt, rvalidNxt, run_r, runNxt;
    logic                      toFlag_r, toFlagNxt;
    logic [1:0]                brespNxt, rrespNxt;

    // pins cross in through two flops
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pinMeta_r <= '0;
            pinSync_r <= '0;
        end else begin
            pinMeta_r <= portPins;
            pinSync_r <= pinMeta_r;
        end
    end

    // fuses and id bits are caught once, at the first edge after release
    always_comb begin
        fuseNxt    = cfgLoaded_r ? fuse_r : fuseWord;
        idNxt      = cfgLoaded_r ? id_r : idBits;
        case (fuseNxt[`FUSE_OSC_LO +: 2])
            `OSC_FUSE_XT: oscModeNxt = harvard_core_pkg::CRYSTAL_OSC_MODE;
            `OSC_FUSE_HS: oscModeNxt = harvard_core_pkg::HIGH_SPEED_OSC_MODE;
            default:      oscModeNxt = harvard_core_pkg::RESISTOR_CAP_OSC_MODE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cfgLoaded_r <= 1'b0;
            fuse_r      <= 12'hFFF;
            id_r        <= 16'hFFFF;
            oscMode_r   <= harvard_core_pkg::RESISTOR_CAP_OSC_MODE;
        end else begin
            cfgLoaded_r <= 1'b1;
            fuse_r      <= fuseNxt;
            id_r        <= idNxt;
            oscMode_r   <= oscModeNxt;
        end
    end

    always_comb begin
        pcNxt = pc_r;  irNxt = ir_r;  wNxt = w_r;  statusNxt = status_r;
        stk1Nxt = stk1_r;  stk2Nxt = stk2_r;  fsrNxt = fsr_r;
        evtNxt = evt_r;  portNxt = port_r;  ramNxt = ram_r;
        wdtNxt = wdtCnt_r;  wdtFire = 1'b0;  flush = 1'b0;
        wrF = 1'b0;  toW = 1'b0;  dfs = 1'b0;  zUpd = 1'b0;  cUpd = 1'b0;
        res = 8'h00;  sum = 9'h000;  tgt = 11'h000;
        active = run_r && cfgLoaded_r;
        lit = ir_r[7:0];
        page = status_r[`ST_PAGE_LO +: 2];
        bitMask = 8'h01 << ir_r[7:5];
        ind = ir_r[4:0] == `F_INDIRECT;
        eAddr = ind ? fsr_r[4:0] : ir_r[4:0];
        eBank = ind ? fsr_r[`FSR_BANK_LO +: 2] : 2'h0;
        ramIdx = eAddr[4] ? RI_W'(8 + 16 * int'(eBank) + int'(eAddr[3:0]))
                          : {4'h0, eAddr[2:0]};
        ramHit = eAddr[4] ? (int'(eBank) < NUM_BANKS) : eAddr[3];
        portSel = eAddr[1:0] - 2'h1;
        if (ramHit) begin
            fRd = ram_r[ramIdx];
        end else begin
            case (eAddr)
                `F_EVENT_CNT: fRd = evt_r;
                `F_PCL:       fRd = pc_r[7:0];
                `F_STATUS:    fRd = status_r;
                `F_INDEX_PTR: fRd = fsr_r;
                `F_PORT_A, `F_PORT_B, `F_PORT_C:
                    fRd = pinSync_r[8 * portSel +: 8];
                default:      fRd = 8'h00;
            endcase
        end
        if (active) begin
            pcNxt = pc_r + 1'b1;
            irNxt = progData;
            evtNxt = evt_r + 8'h01;
            casez (ir_r)
                `OP_STORE_W: begin res = w_r; wrF = 1'b1; end
                `OP_CLEAR:   begin dfs = 1'b1; zUpd = 1'b1; end
                `OP_SUB: begin
                    sum = {1'b0, fRd} + {1'b0, ~w_r} + 9'h001;
                    res = sum[7:0]; dfs = 1'b1; zUpd = 1'b1; cUpd = 1'b1;
                end
                `OP_ADD: begin
                    sum = {1'b0, fRd} + {1'b0, w_r};
                    res = sum[7:0]; dfs = 1'b1; zUpd = 1'b1; cUpd = 1'b1;
                end
                `OP_OR:   begin res = fRd | w_r; dfs = 1'b1; zUpd = 1'b1; end
                `OP_AND:  begin res = fRd & w_r; dfs = 1'b1; zUpd = 1'b1; end
                `OP_XOR:  begin res = fRd ^ w_r; dfs = 1'b1; zUpd = 1'b1; end
                `OP_MOVE: begin res = fRd; dfs = 1'b1; zUpd = 1'b1; end
                `OP_BIT_CLR: begin res = fRd & ~bitMask; wrF = 1'b1; end
                `OP_BIT_SET: begin res = fRd | bitMask; wrF = 1'b1; end
                `OP_SKIP_IF_CLR: flush = (fRd & bitMask) == 8'h00;
                `OP_SKIP_IF_SET: flush = (fRd & bitMask) != 8'h00;
                `OP_RET_LIT: begin
                    pcNxt = stk1_r; stk1Nxt = stk2_r; wNxt = lit; flush = 1'b1;
                end
                `OP_CALL: begin
                    stk1Nxt = pc_r; stk2Nxt = stk1_r; tgt = {page, 1'b0, lit};
                    pcNxt = tgt[PC_W-1:0]; flush = 1'b1;
                end
                `OP_JUMP: begin
                    tgt = {page, ir_r[8:0]}; pcNxt = tgt[PC_W-1:0];
                    flush = 1'b1;
                end
                `OP_LOAD_LIT: wNxt = lit;
                `OP_OR_LIT:  begin res = w_r | lit; toW = 1'b1; zUpd = 1'b1; end
                `OP_AND_LIT: begin res = w_r & lit; toW = 1'b1; zUpd = 1'b1; end
                `OP_XOR_LIT: begin res = w_r ^ lit; toW = 1'b1; zUpd = 1'b1; end
                default: ;
            endcase
            if (dfs) begin
                wrF = ir_r[5];
                toW = !ir_r[5];
            end
            if (zUpd) statusNxt[`ST_Z_BIT] = res == 8'h00;
            if (cUpd) statusNxt[`ST_C_BIT] = sum[8];
            if (toW) wNxt = res;
            if (wrF) begin
                if (ramHit) begin
                    ramNxt[ramIdx] = res;
                end else begin
                    case (eAddr)
                        `F_EVENT_CNT: evtNxt = res;
                        `F_PCL: begin
                            tgt = {page, 1'b0, res};
                            pcNxt = tgt[PC_W-1:0];
                            flush = 1'b1;
                        end
                        `F_STATUS:    statusNxt = res;
                        `F_INDEX_PTR: fsrNxt = res;
                        `F_PORT_A, `F_PORT_B, `F_PORT_C:
                            portNxt[8 * portSel +: 8] = res;
                        default: ;
                    endcase
                end
            end
            if (flush) irNxt = `INSTR_NOP;
            if (ir_r == `OP_WDT_CLEAR || !fuse_r[`FUSE_WDT_EN_BIT]) begin
                wdtNxt = '0;
            end else if (wdtCnt_r == WDT_W'(WDT_CYCLES - 1)) begin
                wdtFire = 1'b1;
                wdtNxt = '0;
                pcNxt = '1;
                irNxt = `INSTR_NOP;
                statusNxt = `STATUS_RST;
            end else begin
                wdtNxt = wdtCnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pc_r     <= '1;
            ir_r     <= `INSTR_NOP;
            stk1_r   <= '0;
            stk2_r   <= '0;
            w_r      <= `W_RST;
            status_r <= `STATUS_RST;
            fsr_r    <= `FSR_RST;
            evt_r    <= 8'h00;
            port_r   <= '0;
            ram_r    <= '{default: 8'h00};
            wdtCnt_r <= '0;
        end else begin
            pc_r     <= pcNxt;
            ir_r     <= irNxt;
            stk1_r   <= stk1Nxt;
            stk2_r   <= stk2Nxt;
            w_r      <= wNxt;
            status_r <= statusNxt;
            fsr_r    <= fsrNxt;
            evt_r    <= evtNxt;
            port_r   <= portNxt;
            ram_r    <= ramNxt;
            wdtCnt_r <= wdtNxt;
        end
    end

    assign awready = !awHeld_r && !bvalid;
    assign wready  = !wHeld_r && !bvalid;
    assign arready = !rvalid;

    always_comb begin
        awHeldNxt = awHeld_r;  wHeldNxt = wHeld_r;  awAddrNxt = awAddr_r;
        wDataNxt = wData_r;  wStrbNxt = wStrb_r;  bvalidNxt = bvalid;
        brespNxt = bresp;  rvalidNxt = rvalid;  rrespNxt = rresp;
        rdataNxt = rdata;  runNxt = run_r;  toFlagNxt = toFlag_r;
        if (awvalid && awready) begin
            awHeldNxt = 1'b1;
            awAddrNxt = awaddr;
        end
        if (wvalid && wready) begin
            wHeldNxt = 1'b1;
            wDataNxt = wdata;
            wStrbNxt = wstrb;
        end
        if (bvalid && bready) bvalidNxt = 1'b0;
        if (awHeldNxt && wHeldNxt && !bvalid) begin
            awHeldNxt = 1'b0;
            wHeldNxt = 1'b0;
            bvalidNxt = 1'b1;
            brespNxt = `RESP_OKAY;
            case (awAddrNxt)
                `REG_CTRL:
                    if (wStrbNxt[0]) runNxt = wDataNxt[`CTRL_RUN_BIT];
                `REG_STATUS:
                    if (wStrbNxt[2] && wDataNxt[`STAT_TO_BIT]) toFlagNxt = 1'b0;
                `REG_WORK, `REG_CONFIG, `REG_IDCODE, `REG_INSTR: ;
                default: brespNxt = `RESP_SLVERR;
            endcase
        end
        // a timeout in the clearing cycle stays set
        if (wdtFire) toFlagNxt = 1'b1;
        if (rvalid && rready) rvalidNxt = 1'b0;
        if (arvalid && arready) begin
            rvalidNxt = 1'b1;
            rrespNxt = `RESP_OKAY;
            rdataNxt = 32'h0000_0000;
            case (araddr)
                `REG_CTRL:   rdataNxt[`CTRL_RUN_BIT] = run_r;
                `REG_STATUS: begin
                    rdataNxt[PC_W-1:0] = pc_r;
                    rdataNxt[`STAT_TO_BIT] = toFlag_r;
                end
                `REG_WORK:   rdataNxt[7:0] = w_r;
                `REG_CONFIG: begin
                    rdataNxt[11:0] = fuse_r;
                    rdataNxt[`CFG_OSC_LO +: 2] = oscMode_r;
                end
                `REG_IDCODE: rdataNxt[15:0] = id_r;
                `REG_INSTR:
                    if (fuse_r[`FUSE_CP_N_BIT]) rdataNxt[11:0] = ir_r;
                default:     rrespNxt = `RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r  <= 32'h0000_0000;
            wStrb_r  <= 4'h0;
            bvalid   <= 1'b0;
            bresp    <= `RESP_OKAY;
            rvalid   <= 1'b0;
            rresp    <= `RESP_OKAY;
            rdata    <= 32'h0000_0000;
            run_r    <= `CTRL_RST;
            toFlag_r <= 1'b0;
        end else begin
            awHeld_r <= awHeldNxt;
            wHeld_r  <= wHeldNxt;
            awAddr_r <= awAddrNxt;
            wData_r  <= wDataNxt;
            wStrb_r  <= wStrbNxt;
            bvalid   <= bvalidNxt;
            bresp    <= brespNxt;
            rvalid   <= rvalidNxt;
            rresp    <= rrespNxt;
            rdata    <= rdataNxt;
            run_r    <= runNxt;
            toFlag_r <= toFlagNxt;
        end
    end

    assign progAddr  = pc_r;
    assign portLatch = port_r;
    assign oscMode   = oscMode_r;

endmodule

// *** harvard_core_defines.svh ***
`ifndef HARVARD_CORE_DEFINES_SVH
`define HARVARD_CORE_DEFINES_SVH

// bus register byte offsets
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_WORK        8'h08
`define REG_CONFIG      8'h0C
`define REG_IDCODE      8'h10
`define REG_INSTR       8'h14
`define CTRL_RUN_BIT    0
`define CTRL_RST        1'b0
`define STAT_TO_BIT     16
`define CFG_OSC_LO      16
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

// file addresses
`define F_INDIRECT      5'h00
`define F_EVENT_CNT     5'h01
`define F_PCL           5'h02
`define F_STATUS        5'h03
`define F_INDEX_PTR     5'h04
`define F_PORT_A        5'h05
`define F_PORT_B        5'h06
`define F_PORT_C        5'h07

// status and index pointer fields, reset values
`define ST_C_BIT        0
`define ST_Z_BIT        2
`define ST_PAGE_LO      5
`define FSR_BANK_LO     5
`define STATUS_RST      8'h18
`define FSR_RST         8'h00
`define W_RST           8'h00
`define INSTR_NOP       12'h000

// fuse word fields; erased bits read as one
`define FUSE_OSC_LO     0
`define FUSE_WDT_EN_BIT 2
`define FUSE_CP_N_BIT   3
`define OSC_FUSE_XT     2'h1
`define OSC_FUSE_HS     2'h2

// instruction patterns
`define OP_WDT_CLEAR    12'b0000_0000_0100
`define OP_STORE_W      12'b0000_001?_????
`define OP_CLEAR        12'b0000_01??_????
`define OP_SUB          12'b0000_10??_????
`define OP_OR           12'b0001_00??_????
`define OP_AND          12'b0001_01??_????
`define OP_XOR          12'b0001_10??_????
`define OP_ADD          12'b0001_11??_????
`define OP_MOVE         12'b0010_00??_????
`define OP_BIT_CLR      12'b0100_????_????
`define OP_BIT_SET      12'b0101_????_????
`define OP_SKIP_IF_CLR  12'b0110_????_????
`define OP_SKIP_IF_SET  12'b0111_????_????
`define OP_RET_LIT      12'b1000_????_????
`define OP_CALL         12'b1001_????_????
`define OP_JUMP         12'b101?_????_????
`define OP_LOAD_LIT     12'b1100_????_????
`define OP_OR_LIT       12'b1101_????_????
`define OP_AND_LIT      12'b1110_????_????
`define OP_XOR_LIT      12'b1111_????_????

`endif

// *** harvard_core_pkg.sv ***
package harvard_core_pkg;

    typedef enum logic [1:0] {
        RESISTOR_CAP_OSC_MODE,
        CRYSTAL_OSC_MODE,
        HIGH_SPEED_OSC_MODE
    } osc_mode_t;

endpackage

// *** harvard_core_props.sv ***
`timescale 1ns/10ps
`include "harvard_core_defines.svh"
module harvard_core_props #(
    parameter int PC_W = 11
) (
    // clock and reset
    input wire logic                        clk_sys,
    input wire logic                        arst_n,
    // register bus
    input wire logic [7:0]                  araddr,
    input wire logic                        arvalid,
    input wire logic                        arready,
    input wire logic [31:0]                 rdata,
    input wire logic [1:0]                  rresp,
    input wire logic                        rvalid,
    input wire logic [1:0]                  bresp,
    input wire logic                        bvalid,
    // program side
    input wire logic [PC_W-1:0]             progAddr,
    input wire logic [11:0]                 progData,
    input wire logic [11:0]                 fuseWord,
    input wire logic [15:0]                 idBits,
    input wire harvard_core_pkg::osc_mode_t oscMode
);
    logic [7:0] rdAddr_r;
    logic [7:0] rdAddr_nxt;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // address of the read whose answer is pending
    always_comb begin
        rdAddr_nxt = (arvalid && arready) ? araddr : rdAddr_r;
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdAddr_r <= 8'h00;
        end else begin
            rdAddr_r <= rdAddr_nxt;
        end
    end

    reset_pc_a: assert property ($rose(arst_n) |-> progAddr == '1)
        else $error("fetch address not all ones after reset");
    jump_target_a: assert property (
        progData ==? `OP_JUMP ##1 progAddr == $past(progAddr) + 1'b1
        |=> progAddr[8:0] == $past(progData[8:0], 2) || progAddr == '1)
        else $error("jump did not load its target");
    call_target_a: assert property (
        progData ==? `OP_CALL ##1 progAddr == $past(progAddr) + 1'b1
        |=> progAddr[8:0] == {1'b0, $past(progData[7:0], 2)}
            || progAddr == '1)
        else $error("call did not load its target");
    flush_step_a: assert property (
        progAddr != $past(progAddr) + 1'b1 && !$stable(progAddr)
            && progAddr != '1
        |=> progAddr == $past(progAddr) + 1'b1 || $stable(progAddr)
            || progAddr == '1)
        else $error("flow change not followed by a discarded slot");
    osc_mode_a: assert property (
        $past(arst_n) |-> oscMode == (fuseWord[1:0] == `OSC_FUSE_XT
            ? harvard_core_pkg::CRYSTAL_OSC_MODE
            : fuseWord[1:0] == `OSC_FUSE_HS
            ? harvard_core_pkg::HIGH_SPEED_OSC_MODE
            : harvard_core_pkg::RESISTOR_CAP_OSC_MODE))
        else $error("oscillator mode does not follow fuses");
    code_protect_a: assert property (
        rvalid && rdAddr_r == `REG_INSTR && !fuseWord[`FUSE_CP_N_BIT]
        |-> rdata == 32'h00000000)
        else $error("protected instruction word was readable");
    id_bits_a: assert property (
        rvalid && rdAddr_r == `REG_IDCODE |-> rdata[15:0] == idBits)
        else $error("id code read differs from id fuses");
    fuse_config_a: assert property (
        rvalid && rdAddr_r == `REG_CONFIG |-> rdata[11:0] == fuseWord)
        else $error("config read differs from fuses");

    cover property (progData ==? `OP_CALL ##1
        progAddr == $past(progAddr) + 1'b1);
    cover property (rvalid && rresp == `RESP_SLVERR);
    cover property (bvalid && bresp == `RESP_SLVERR);
endmodule

bind harvard_core harvard_core_props #(.PC_W(PC_W)) u_props (
    .clk_sys(clk_sys), .arst_n(arst_n), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .bresp(bresp), .bvalid(bvalid),
    .progAddr(progAddr), .progData(progData), .fuseWord(fuseWord),
    .idBits(idBits), .oscMode(oscMode)
);

// *** prog_rom_model.sv ***
`timescale 1ns/10ps
module prog_rom_model #(
    parameter int AW = 11
) (
    // fetch port
    input  wire logic [AW-1:0] progAddr,
    output logic      [11:0]   progData,
    // configuration fuses
    output logic      [11:0]   fuseWord,
    output logic      [15:0]   idBits
);
    logic [11:0] mem [2**AW];
    logic [11:0] fuse;
    logic [15:0] ids;

    initial begin
        foreach (mem[i]) begin
            mem[i] = 12'hFFF;
        end
        fuse = 12'hFFF;
        ids = 16'hFFFF;
    end
    assign progData = mem[progAddr];
    assign fuseWord = fuse;
    assign idBits = ids;
endmodule

// *** tb.sv ***
`timescale 1ns/10ps
`include "harvard_core_defines.svh"
module tb;
    logic        clk_sys, arst_n, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, rs;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [10:0] progAddr;
    logic [11:0] progData, fuseWord;
    logic [15:0] idBits;
    logic [23:0] portPins, portLatch;
    harvard_core_pkg::osc_mode_t oscMode;
    int          errors, checks;

    harvard_core #(.WDT_CYCLES(16)) u_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .progAddr(progAddr), .progData(progData),
        .fuseWord(fuseWord), .idBits(idBits), .portPins(portPins),
        .portLatch(portLatch), .oscMode(oscMode)
    );
    prog_rom_model u_rom (
        .progAddr(progAddr), .progData(progData), .fuseWord(fuseWord),
        .idBits(idBits)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d, errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic do_reset(input logic [11:0] f);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        u_rom.fuse <= f;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        // fuses are captured at the first edge after release and show right after that edge
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [1:0] r);
        bit awDone;
        bit wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        r = 2'h1;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (bvalid) begin
                r = bresp;
                break;
            end
            if (awready && !awDone) begin
                awDone = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !wDone) begin
                wDone = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        bit arDone;
        arDone = 1'b0;
        d = 32'hFFFFFFFF;
        r = 2'h1;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (rvalid) begin
                d = rdata;
                r = rresp;
                break;
            end
            if (arready && !arDone) begin
                arDone = 1'b1;
                arvalid <= 1'b0;
            end
        end
        rready <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic t_fuses;
        int e;
        u_rom.ids <= 16'hA5C3;
        for (int i = 0; i < 4; i++) begin
            e = (i == 1) ? 1 : (i == 2) ? 2 : 0;
            do_reset({10'h3FF, i[1:0]});
            check(32'(progAddr), 32'h000007FF);
            check(32'(oscMode), e);
            axi_rd(`REG_CONFIG, rd, rs);
            check(rd & 32'h00030FFF, {14'h0, e[1:0], 4'h0, 10'h3FF, i[1:0]});
        end
    endtask

    task automatic t_bus;
        axi_rd(8'h18, rd, rs);
        check(32'(rs), 32'(`RESP_SLVERR));
        check(rd, 32'h00000000);
        axi_wr(8'h1C, 32'h00000001, 4'hF, rs);
        check(32'(rs), 32'(`RESP_SLVERR));
        axi_wr(`REG_IDCODE, 32'h00001234, 4'hF, rs);
        check(32'(rs), 32'(`RESP_OKAY));
        axi_rd(`REG_IDCODE, rd, rs);
        check(rd & 32'h0000FFFF, 32'h0000A5C3);
    endtask

    // erased fuses leave the watchdog running
    task automatic t_watchdog;
        axi_wr(`REG_CTRL, 32'h00000001, 4'h1, rs);
        repeat (40) @(posedge clk_sys);
        axi_wr(`REG_CTRL, 32'h00000000, 4'h1, rs);
        axi_rd(`REG_STATUS, rd, rs);
        check(32'(rd[16]), 32'h00000001);
        axi_wr(`REG_STATUS, 32'h00010000, 4'h4, rs);
        axi_rd(`REG_STATUS, rd, rs);
        check(32'(rd[16]), 32'h00000000);
    endtask

    // pointer, indirect store, skip, three nested calls
    task automatic t_program;
        logic [23:0] prog [19] = '{
            24'h000C10, 24'h001024, 24'h002C33, 24'h003020, 24'h004C00,
            24'h005210, 24'h0061C0, 24'h007025, 24'h008605, 24'h009C99,
            24'h00A026, 24'h00B920, 24'h00CA0C, 24'h020930, 24'h021877,
            24'h030940, 24'h031844, 24'h040822, 24'h7FFA00};
        foreach (prog[i]) begin
            u_rom.mem[prog[i][23:12]] = prog[i][11:0];
        end
        do_reset(12'hFF1);
        axi_wr(`REG_CTRL, 32'h00000001, 4'h1, rs);
        repeat (60) @(posedge clk_sys);
        axi_wr(`REG_CTRL, 32'h00000000, 4'h1, rs);
        check(32'(oscMode), 32'h00000001);
        check(32'(portLatch), 32'h00006666);
        axi_rd(`REG_WORK, rd, rs);
        check(32'(rd[7:0]), 32'h00000077);
        axi_rd(`REG_STATUS, rd, rs);
        check(32'(rd[10:0] inside {11'h021, 11'h022}), 32'h1);
        check(32'(rd[16]), 32'h00000000);
        axi_rd(`REG_INSTR, rd, rs);
        check(rd, 32'h00000000);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial begin
        arst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        wstrb = 4'h0;
        portPins = 24'h5A5A00;
        errors = 0;
        checks = 0;
        t_fuses();
        t_bus();
        t_watchdog();
        t_program();
        complete_run();
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        complete_run();
    end
endmodule
